// ### rtl/cmpf_pkg.sv
package cmpf_pkg;
    // Frame geometry
    localparam int unsigned SRC_BYTES = 60;            // Network source bytes per frame
    localparam int unsigned FRAME_BYTES = 64;          // Source bytes plus status quadlet
    localparam int unsigned SUBFRAMES = 8;             // Subframe intervals per frame
    localparam int unsigned BYTES_PER_SF = 8;          // FIFO bytes per interval per direction
    localparam logic [5:0] STAT_SBC_REF = 6'h3c;       // Routing refs of the status bytes
    localparam logic [5:0] STAT_START_REF = 6'h3d;
    localparam logic [5:0] STAT_RSVD_REF = 6'h3e;
    localparam logic [5:0] STAT_ERROR_REF = 6'h3f;
    // Packet layout
    localparam logic [3:0] PKT_LEN_POS = 4'h3;         // Length byte index
    localparam logic [3:0] PKT_HDR_BYTES = 4'h4;       // Arb, dest hi, dest lo, length
    localparam logic [7:0] LEN_MIN = 8'h01;
    localparam logic [7:0] LEN_MAX_COMBINED = 8'hfe;
    localparam logic [7:0] LEN_MAX_OTHER = 8'h0d;
    localparam logic [1:0] CRC_BYTES = 2'h2;           // Trailing CRC bytes
    localparam logic [15:0] CRC_INIT = 16'hffff;       // CRC seed
    localparam logic [15:0] CRC_POLY = 16'h1021;       // CRC polynomial
    // Register map (AHB-Lite byte addresses)
    localparam logic [8:0] ADDR_CTRL = 9'h000;         // [0] activate, [1] sync mode
    localparam logic [8:0] ADDR_SBC = 9'h004;          // [3:0] sync bandwidth quadlets
    localparam logic [8:0] ADDR_STATUS = 9'h008;       // Block state
    localparam logic [8:0] ADDR_RT_BASE = 9'h080;      // Routing table upper half, 64 words
    localparam logic [8:0] ADDR_RT_END = 9'h180;       // First byte past the table
    localparam logic [3:0] SBC_RESET = 4'hf;           // All synchronous after reset
    // Status byte values
    localparam logic [7:0] FLAG_SET = 8'h01;
    localparam logic [7:0] FLAG_CLR = 8'h00;
    typedef enum logic [1:0] {TX_IDLE, TX_BODY, TX_CRC_HI, TX_CRC_LO} cmpf_tx_t;
endpackage

// ### rtl/cmpf_route_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Upper routing table: 64 entries of 6-bit references, registered read
module cmpf_route_mem
    import cmpf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_we,
    input wire logic [5:0] i_waddr,
    input wire logic [5:0] i_wdata,
    input wire logic [5:0] i_raddr,
    output logic [5:0] o_rdata,
    input wire logic [5:0] i_saddr,
    output logic [5:0] o_sdata
);
    logic [5:0] mem [64];  // Reset to identity mapping

    // Writes, with identity fill on reset so status lands at frame end
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 64; i++) begin
            if (i_srst) begin
                mem[i] <= 6'(i);
            end else if (i_we && i_waddr == 6'(i)) begin
                mem[i] <= i_wdata;
            end
        end
    end

    // Registered read ports, one for software, one for the frame stream
    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
        o_sdata <= mem[i_saddr];
    end
endmodule
`default_nettype wire

// ### rtl/cmpf_crc16.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-wide CRC step, one byte per enabled cycle
module cmpf_crc16
    import cmpf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic i_en,
    input wire logic [7:0] i_byte,
    output logic [15:0] o_crc
);
    logic [15:0] next_crc;  // Combinational step result

    // Eight serial shifts unrolled by the loop
    always_comb begin
        next_crc = o_crc;
        for (int b = 7; b >= 0; b--) begin
            if (next_crc[15] ^ i_byte[b]) begin
                next_crc = {next_crc[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                next_crc = {next_crc[14:0], 1'b0};
            end
        end
    end

    // Clear wins over step so a new packet never inherits a stale sum
    always_ff @(posedge i_clk) begin
        if (i_srst || i_clear) begin
            o_crc <= CRC_INIT;
        end else if (i_en) begin
            o_crc <= next_crc;
        end
    end
endmodule
`default_nettype wire

// ### rtl/cmpf_framer.sv
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cmpf_framer
    import cmpf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [8:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Network receive side, one source byte per strobe, byte 0 after frame start
    input wire logic i_net_frame_start,
    input wire logic i_net_rx_valid,
    input wire logic [7:0] i_net_rx_byte,
    // Network transmit side, packet bytes taken from the controller
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_tx_last,
    output logic o_tx_out_valid,
    output logic [7:0] o_tx_out_byte,
    // Parallel port toward the controller
    output logic o_fifo_valid,
    output logic [7:0] o_fifo_byte,
    output logic o_frame_sync_pin,
    output logic [2:0] o_fifo_subframe_interval
);
    logic combined_mode_activate;    // Activate bit
    logic sync_mode;                 // Source port in parallel-synchronous mode
    logic [3:0] sync_bandwidth_register;
    logic combined;                  // Mode truly active
    logic [5:0] rx_pos;              // Received source byte index
    logic [7:0] rx_buf [60];         // Frame receive bytes
    logic rx_in_pkt;                 // Inside a packet
    logic [9:0] rx_remain;           // Packet bytes still expected
    logic rx_hdr;                    // Next async byte is a header byte
    logic [2:0] rx_hdr_pos;          // Header byte index
    logic start_flag;                // Status byte 1 source
    logic error_flag;                // Status byte 3 source
    logic [5:0] out_pos;             // Streamed FIFO slot
    logic out_busy;                  // Streaming phase
    logic out_busy_d;                // Aligned with memory read
    logic [5:0] out_ref;             // Reference from table
    logic [5:0] out_pos_d;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic rx_crc_en;
    logic rx_crc_clear;
    logic [7:0] rx_len;
    logic rx_async;                  // Byte is in packet region
    logic [15:0] rx_crc_tail;        // Received CRC bytes
    cmpf_tx_t tx_state;
    logic [7:0] tx_len;
    logic [7:0] len_max;
    logic ap_pending;                // Bus transfer waiting for data phase
    logic [8:0] ap_addr;
    logic [6:0] sw_word, ap_word;    // Word index relative to table base
    logic ap_write;
    logic rt_we;
    logic [5:0] rt_rdata;
    logic [5:0] sw_raddr;

    assign combined = combined_mode_activate && sync_mode;
    assign len_max = combined ? LEN_MAX_COMBINED : LEN_MAX_OTHER;
    assign rx_async = rx_pos >= {sync_bandwidth_register, 2'b00};  // Bytes past sync share

    // Address phase capture; bus always ready, always OKAY
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ap_pending <= 1'b0;
            ap_addr <= 9'h000;
            ap_write <= 1'b0;
        end else if (i_hready) begin
            ap_pending <= i_hsel && i_htrans[1];
            ap_addr <= i_haddr;
            ap_write <= i_hwrite;
        end
    end
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    // Table needs all 64 words, so the bus is one bit wider than 8
    assign sw_word = i_haddr[8:2] - ADDR_RT_BASE[8:2];
    assign ap_word = ap_addr[8:2] - ADDR_RT_BASE[8:2];
    assign sw_raddr = sw_word[5:0];
    assign rt_we = ap_pending && ap_write && ap_addr >= ADDR_RT_BASE && ap_addr < ADDR_RT_END;

    // Control register writes
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            combined_mode_activate <= 1'b0;
            sync_mode <= 1'b0;
            sync_bandwidth_register <= SBC_RESET;
        end else if (ap_pending && ap_write) begin
            if (ap_addr == ADDR_CTRL) begin
                combined_mode_activate <= i_hwdata[0];
                sync_mode <= i_hwdata[1];
            end else if (ap_addr == ADDR_SBC) begin
                sync_bandwidth_register <= i_hwdata[3:0];
            end
        end
    end

    // Read data; table read is registered so muxed by captured address
    always_comb begin
        if (!ap_pending || ap_write) begin
            o_hrdata = 32'h0000_0000;
        end else if (ap_addr == ADDR_CTRL) begin
            o_hrdata = {30'h0, sync_mode, combined_mode_activate};
        end else if (ap_addr == ADDR_SBC) begin
            o_hrdata = {28'h0, sync_bandwidth_register};
        end else if (ap_addr == ADDR_STATUS) begin
            o_hrdata = {26'h0, tx_state, error_flag, start_flag, rx_in_pkt, combined};
        end else if (ap_addr >= ADDR_RT_BASE && ap_addr < ADDR_RT_END) begin
            o_hrdata = {26'h0, rt_rdata};
        end else begin
            o_hrdata = 32'h0000_0000;
        end
    end

    cmpf_route_mem u_rt (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_we(rt_we),
        .i_waddr(ap_word[5:0]),
        .i_wdata(i_hwdata[5:0]),
        .i_raddr(sw_raddr),
        .o_rdata(rt_rdata),
        .i_saddr(out_pos),
        .o_sdata(out_ref)
    );

    // Receive byte capture and packet parse
    always_ff @(posedge i_clk) begin
        if (i_srst || i_net_frame_start) begin
            rx_pos <= 6'h00;
        end else if (i_net_rx_valid && rx_pos < 6'(SRC_BYTES)) begin
            rx_buf[rx_pos] <= i_net_rx_byte;
            rx_pos <= rx_pos + 6'h01;
        end
    end

    assign rx_crc_clear = i_srst || (i_net_rx_valid && rx_async && !rx_in_pkt);
    // Header bytes never enter the sum, even with a stale remain count
    assign rx_crc_en = i_net_rx_valid && rx_async && rx_in_pkt && !rx_hdr && rx_remain > 10'(CRC_BYTES);

    cmpf_crc16 u_rx_crc (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_clear(rx_crc_clear),
        .i_en(rx_crc_en),
        .i_byte(i_net_rx_byte),
        .o_crc(rx_crc)
    );

    // Packet tracking: any nonzero async byte outside a packet opens a packet
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_in_pkt <= 1'b0;
            rx_remain <= 10'h000;
            rx_hdr_pos <= 3'h0;
            rx_len <= 8'h00;
            rx_crc_tail <= 16'h0000;
            start_flag <= 1'b0;
            error_flag <= 1'b0;
            rx_hdr <= 1'b0;
        end else if (i_net_frame_start) begin
            start_flag <= 1'b0;
            error_flag <= 1'b0;
            // Frame start with a packet still open outside combined mode: premature end
            if (rx_in_pkt && !combined) begin
                rx_in_pkt <= 1'b0;
            end
        end else if (i_net_rx_valid && rx_async && rx_pos < 6'(SRC_BYTES)) begin
            if (!rx_in_pkt) begin
                if (i_net_rx_byte != 8'h00) begin  // Arbitration byte
                    rx_in_pkt <= 1'b1;
                    start_flag <= 1'b1;
                    rx_hdr <= 1'b1;
                    rx_hdr_pos <= 3'h1;
                end
            end else if (rx_hdr) begin
                rx_hdr_pos <= rx_hdr_pos + 3'h1;
                if (rx_hdr_pos == PKT_LEN_POS[2:0]) begin
                    rx_hdr <= 1'b0;
                    rx_len <= i_net_rx_byte;
                    if (i_net_rx_byte < LEN_MIN || i_net_rx_byte > len_max) begin
                        error_flag <= 1'b1;
                        rx_in_pkt <= 1'b0;
                    end else begin
                        // Length quadlets cover source plus data, then CRC
                        rx_remain <= {i_net_rx_byte, 2'b00} + 10'(CRC_BYTES);
                    end
                end
            end else begin
                rx_remain <= rx_remain - 10'h001;
                if (rx_remain <= 10'(CRC_BYTES)) begin
                    rx_crc_tail <= {rx_crc_tail[7:0], i_net_rx_byte};
                end
                if (rx_remain == 10'h001) begin
                    rx_in_pkt <= 1'b0;
                    if ({rx_crc_tail[7:0], i_net_rx_byte} != rx_crc) begin
                        error_flag <= 1'b1;
                    end
                end
            end
        end
    end

    // Stream frame to the FIFO after the last source byte
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            out_busy <= 1'b0;
            out_pos <= 6'h00;
            out_busy_d <= 1'b0;
            out_pos_d <= 6'h00;
        end else begin
            out_busy_d <= out_busy;
            out_pos_d <= out_pos;
            if (combined && i_net_rx_valid && rx_pos == 6'(SRC_BYTES - 1)) begin
                out_busy <= 1'b1;
                out_pos <= 6'h00;
            end else if (out_busy) begin
                out_pos <= out_pos + 6'h01;
                if (out_pos == 6'(FRAME_BYTES - 1)) begin
                    out_busy <= 1'b0;
                end
            end
        end
    end

    // Byte selection through routing reference; status refs are 3c..3f
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_fifo_valid <= 1'b0;
            o_fifo_byte <= 8'h00;
        end else begin
            o_fifo_valid <= out_busy_d;
            if (out_ref == STAT_SBC_REF) begin
                o_fifo_byte <= {4'h0, sync_bandwidth_register};
            end else if (out_ref == STAT_START_REF) begin
                o_fifo_byte <= start_flag ? FLAG_SET : FLAG_CLR;
            end else if (out_ref == STAT_RSVD_REF) begin
                o_fifo_byte <= 8'h00;
            end else if (out_ref == STAT_ERROR_REF) begin
                o_fifo_byte <= error_flag ? FLAG_SET : FLAG_CLR;
            end else begin
                o_fifo_byte <= rx_buf[out_ref];
            end
        end
    end

    // Frame sync low during first half, interval index from stream slot
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_frame_sync_pin <= 1'b1;
            o_fifo_subframe_interval <= 3'h0;
        end else begin
            o_frame_sync_pin <= !(out_busy_d && out_pos_d < 6'(FRAME_BYTES / 2));
            o_fifo_subframe_interval <= out_pos_d[5:3];
        end
    end

    cmpf_crc16 u_tx_crc (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_clear(tx_state == TX_IDLE),
        .i_en(i_tx_valid && tx_state == TX_BODY && tx_len >= 8'(PKT_HDR_BYTES)),  // Source through data
        .i_byte(i_tx_byte),
        .o_crc(tx_crc)
    );

    // Transmit: pass packet bytes, then append CRC
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tx_state <= TX_IDLE;
            o_tx_out_valid <= 1'b0;
            o_tx_out_byte <= 8'h00;
            tx_len <= 8'h00;
        end else begin
            o_tx_out_valid <= 1'b0;
            case (tx_state)
                TX_IDLE, TX_BODY: begin
                    if (i_tx_valid) begin
                        o_tx_out_valid <= 1'b1;
                        o_tx_out_byte <= i_tx_byte;
                        tx_state <= i_tx_last ? TX_CRC_HI : TX_BODY;
                        tx_len <= (tx_len < 8'(PKT_HDR_BYTES)) ? tx_len + 8'h01 : tx_len;  // Saturates past header
                    end
                end
                TX_CRC_HI: begin
                    o_tx_out_valid <= 1'b1;
                    o_tx_out_byte <= tx_crc[15:8];
                    tx_state <= TX_CRC_LO;
                end
                TX_CRC_LO: begin
                    o_tx_out_valid <= 1'b1;
                    o_tx_out_byte <= tx_crc[7:0];
                    tx_state <= TX_IDLE;
                    tx_len <= 8'h00;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    a_fifo_count: assert property (@(posedge i_clk) disable iff (i_srst)
        (out_busy && out_pos != 6'(FRAME_BYTES - 1)) |=> out_busy)
        else $error("stream ended early");
    a_crc_append: assert property (@(posedge i_clk) disable iff (i_srst)
        (tx_state == TX_CRC_HI) |=> (tx_state == TX_CRC_LO) ##1 (tx_state == TX_IDLE && o_tx_out_valid))
        else $error("crc not appended");
    a_mode_gate: assert property (@(posedge i_clk) disable iff (i_srst)
        combined |-> (combined_mode_activate && sync_mode))
        else $error("combined without sync mode");
    a_start_clear: assert property (@(posedge i_clk) disable iff (i_srst)
        i_net_frame_start |=> !start_flag)
        else $error("start flag not cleared");
    a_status_bw: assert property (@(posedge i_clk) disable iff (i_srst)
        (out_busy_d && out_ref == STAT_SBC_REF) |=> (o_fifo_byte == {4'h0, $past(sync_bandwidth_register)}))
        else $error("bandwidth status wrong");
    a_len_check: assert property (@(posedge i_clk) disable iff (i_srst)
        (rx_in_pkt && !rx_hdr && !$past(rx_hdr) && $past(rx_in_pkt)) |-> (rx_len >= LEN_MIN))
        else $error("bad length accepted");
    a_fifo_valid: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(o_fifo_valid) |-> (o_fifo_subframe_interval == 3'h0))
        else $error("interval misaligned");
    a_error_src: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(error_flag) |-> ($past(i_net_rx_valid) && $past(rx_in_pkt)))
        else $error("error without packet byte");
endmodule
`default_nettype wire

// ### testbench/cmpf_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller model: gathers each 64-byte burst from the parallel port
module cmpf_ctl_model
    import cmpf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_fifo_valid,
    input wire logic [7:0] i_fifo_byte,
    output logic [7:0] o_buf [FRAME_BYTES],
    output logic [7:0] o_frames
);
    logic [5:0] cnt; // Byte slot within the burst
    // Keeps every byte; the reserved one is stored but never interpreted
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt <= 6'h00;
            o_frames <= 8'h00;
        end else if (i_fifo_valid) begin
            o_buf[cnt] <= i_fifo_byte; // Reads every slot of every interval
            cnt <= cnt + 6'h01;
            if (cnt == 6'h3f) begin
                o_frames <= o_frames + 8'h01; // Whole frame, unneeded bytes included
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/combined_mode_packet_rx_framing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module combined_mode_packet_rx_framing_tb
    import cmpf_pkg::*;
;
    logic i_clk = 0, i_srst = 1, hsel = 0, hwrite = 0, fs = 0, rxv = 0, txv = 0, txl = 0;
    logic [8:0] haddr = 9'h000;
    logic [7:0] rxb = 8'h00, txb = 8'h00, frames;
    logic [5:0] slot = 6'h00;
    logic [2:0] sfi;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hready, hresp, txov, fv, fsp;
    logic [7:0] txob, fb, fbuf [FRAME_BYTES], fr [SRC_BYTES], txq [$];
    int n_errors = 0, total_checks = 0, cyc = 0;
    cmpf_framer u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_net_frame_start(fs), .i_net_rx_valid(rxv),
        .i_net_rx_byte(rxb), .i_tx_valid(txv), .i_tx_byte(txb), .i_tx_last(txl), .o_tx_out_valid(txov),
        .o_tx_out_byte(txob), .o_fifo_valid(fv), .o_fifo_byte(fb), .o_frame_sync_pin(fsp),
        .o_fifo_subframe_interval(sfi));
    cmpf_ctl_model u_ctl (.i_clk(i_clk), .i_srst(i_srst), .i_fifo_valid(fv), .i_fifo_byte(fb),
        .o_buf(fbuf), .o_frames(frames));
    // Free-running 100 MHz clock
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // Transmit monitor and hang guard
    always @(posedge i_clk) begin
        if (txov === 1'b1) begin
            txq.push_back(txob);
        end
        // Frame sync low in the first half, interval index per eight slots
        if (fv === 1'b1) begin
            chk({fsp, sfi}, {slot >= 6'd32, slot[5:3]});
            slot <= slot + 6'h01;
        end
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Single AHB-Lite transfer; waits on ready in both phases
    task automatic ahb(input logic wr, input logic [8:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge i_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
        chk(hresp, 32'h0);
    endtask
    // Mid-run reset drops any open packet, then combined mode at this bandwidth
    task automatic restart(input int sync_bandwidth_quadlets);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        ahb(1, ADDR_CTRL, 32'h3);
        ahb(1, ADDR_SBC, 32'(sync_bandwidth_quadlets));
    endtask
    // Software-side CRC step, MSB first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction
    // Builds a frame: sync filler, then optionally a one-quadlet packet at sbc*4
    task automatic build(input int sync_bandwidth_quadlets, input logic [7:0] len, input logic bad, input logic pkt);
        logic [15:0] c;
        int p;
        p = sync_bandwidth_quadlets * 4;
        c = CRC_INIT;
        for (int k = 0; k < 60; k++) begin
            fr[k] = (k < p) ? 8'(k + 8'h80) : 8'h00;
        end
        if (pkt) begin
            {fr[p], fr[p+1], fr[p+2], fr[p+3]} = {8'h07, 8'h01, 8'h23, len};
            {fr[p+4], fr[p+5], fr[p+6], fr[p+7]} = 32'h0222aabb; // Length*4-2 = two data bytes
            for (int k = 4; k < 8; k++) begin
                c = crc_step(c, fr[p+k]); // CRC spans source through data
            end
            {fr[p+8], fr[p+9]} = c ^ {15'h0, bad};
        end
    endtask
    // Sends a frame on the network side; returns whether a burst reached the controller
    task automatic send(output logic got);
        logic [7:0] f0;
        f0 = frames;
        fs <= 1'b1;
        @(posedge i_clk);
        fs <= 1'b0;
        for (int k = 0; k < 60; k++) begin
            rxv <= 1'b1;
            rxb <= fr[k];
            @(posedge i_clk);
        end
        rxv <= 1'b0;
        got = 1'b0;
        for (int w = 0; w < 200 && !got; w++) begin
            @(posedge i_clk);
            got = (frames != f0);
        end
    endtask
    // Receive frame check, status at the end of the frame
    task automatic t_rx(input int sync_bandwidth_quadlets, input logic [7:0] len, input logic bad, input logic pkt, input logic err);
        logic got;
        restart(sync_bandwidth_quadlets);
        build(sync_bandwidth_quadlets, len, bad, pkt);
        send(got);
        chk(got, 1'b1);
        for (int k = 0; k < 60; k++) begin
            chk(fbuf[k], fr[k]);
        end
        chk(fbuf[60], {4'h0, 4'(sync_bandwidth_quadlets)});
        chk(fbuf[61], {7'h0, pkt});
        chk(fbuf[63], {7'h0, err});
        if (pkt) begin
            chk(fbuf[sync_bandwidth_quadlets*4+3], len); // Length at bandwidth*4+3
        end
        $display("test rx sbc %0d len %0d done", sync_bandwidth_quadlets, len);
    endtask
    initial begin
        logic got;
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        // Register defaults and an unmapped place
        ahb(0, ADDR_SBC, 0);
        chk(rd[3:0], SBC_RESET);
        ahb(0, 9'h094, 0);
        chk(rd[5:0], 6'h05);
        ahb(1, 9'h040, 32'hffffffff);
        ahb(0, 9'h040, 0);
        chk(rd, 32'h0);
        $display("test regs done");
        // Activate without sync mode, then sync without activate: no burst
        ahb(1, ADDR_CTRL, 32'h1);
        send(got);
        chk(got, 1'b0);
        ahb(1, ADDR_CTRL, 32'h2);
        send(got);
        chk(got, 1'b0);
        ahb(1, ADDR_CTRL, 32'h3);
        ahb(1, ADDR_SBC, 32'ha);
        ahb(0, ADDR_SBC, 0);
        chk(rd[3:0], 4'ha);
        $display("test activate done");
        t_rx(10, 8'h01, 0, 1, 0);
        t_rx(10, 8'h01, 1, 1, 1); // Corrupt CRC
        t_rx(10, 8'h00, 0, 1, 1); // Zero length refused
        t_rx(10, 8'h01, 0, 0, 0); // No packet start
        t_rx(0, 8'hfe, 0, 1, 0); // Full combined maximum
        // Status moved to the boundary for bandwidth 4
        restart(4);
        for (int i = 16; i < 64; i++) begin
            ahb(1, ADDR_RT_BASE + 9'(4 * i), (i < 20) ? 32'(i + 44) : 32'(i - 4));
        end
        ahb(0, ADDR_RT_BASE + 9'd64, 0);
        chk(rd[5:0], STAT_SBC_REF);
        build(4, 8'h01, 0, 1);
        send(got);
        chk(got, 1'b1);
        for (int k = 0; k < 64; k++) begin
            chk(fbuf[k], (k < 16) ? fr[k] : (k < 20) ? {7'h0, k == 17} | ((k == 16) ? 8'h04 : 8'h00)
                : fr[k-4]);
        end
        chk(fbuf[23], 8'h01); // Length at bandwidth*4+7
        $display("test moved done");
        // Transmit: packet bytes pass, CRC appended
        txq.delete();
        build(0, 8'h01, 0, 1);
        for (int i = 0; i < 8; i++) begin
            txv <= 1'b1;
            txb <= fr[i];
            txl <= (i == 7);
            @(posedge i_clk);
        end
        txv <= 1'b0;
        txl <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk(txq.size(), 10);
        for (int i = 0; i < 10 && i < txq.size(); i++) begin
            chk(txq[i], fr[i]);
        end
        $display("test tx done");
        conclude();
    end
endmodule
`default_nettype wire
